/* hdl/tcp_capture_filter.sv */
// capture pin synchroniser, noise canceller and edge detector
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tcp_capture_filter
  import tcp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and control
  input  wire logic capture_input_pin,
  input  wire logic capture_edge_select,
  input  wire logic capture_noise_cancel,
  // capture trigger pulse
  output logic      capture_trig
);
  logic       sync1_r;    // first stage, read only by sync2_r
  logic       sync2_r;    // second stage
  logic       level_r;    // accepted filtered level
  logic [2:0] run_r;      // successive samples differing from level
  logic [2:0] run_nxt;
  logic       level_nxt;
  logic       changed;
  logic       want_edge;

  // count differing samples; canceller needs four in a row
  assign changed   = sync2_r != level_r;
  assign run_nxt   = !changed ? `TCP_NC_ZERO :
                     (run_r == `TCP_NC_MAX) ? run_r : run_r + `TCP_NC_ONE;
  assign level_nxt = changed && (!capture_noise_cancel ||
                     run_nxt == `TCP_NC_SAMPLES) ? sync2_r : level_r; // RL15
  // rising when select set, falling when cleared
  assign want_edge = (level_nxt != level_r) &&
                     (level_nxt == capture_edge_select); // RL14

  // two-flop synchroniser and filter state
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r      <= 1'b0;
      sync2_r      <= 1'b0;
      level_r      <= 1'b0;
      run_r        <= `TCP_NC_ZERO;
      capture_trig <= 1'b0;
    end else begin
      sync1_r      <= capture_input_pin;
      sync2_r      <= sync1_r;
      level_r      <= level_nxt;
      run_r        <= level_nxt != level_r ? `TCP_NC_ZERO : run_nxt;
      capture_trig <= want_edge;
    end
  end
endmodule : tcp_capture_filter

/* hdl/tcp_defines.svh */
// constants for the wide timer capture and pwm block
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH
// register byte addresses on the i/o bus
`define TCP_ADDR_CNT_L   6'h2c
`define TCP_ADDR_CNT_H   6'h2d
`define TCP_ADDR_CMPA_L  6'h2a
`define TCP_ADDR_CMPA_H  6'h2b
`define TCP_ADDR_CMPB_L  6'h28
`define TCP_ADDR_CMPB_H  6'h29
`define TCP_ADDR_CAP_L   6'h26
`define TCP_ADDR_CAP_H   6'h27
// pwm top values
`define TCP_TOP_8        16'h00ff
`define TCP_TOP_9        16'h01ff
`define TCP_TOP_10       16'h03ff
`define TCP_ZERO16       16'h0000
`define TCP_ONE16        16'h0001
`define TCP_ALL_ONES16   16'hffff
// noise canceller sample count
`define TCP_NC_SAMPLES   3'h4
`define TCP_NC_MAX       3'h4
`define TCP_NC_ONE       3'h1
`define TCP_NC_ZERO      3'h0
// compare output mode field values
`define TCP_OM_CLR_UP    2'h2
`define TCP_OM_SET_UP    2'h3
`endif

/* hdl/tcp_pkg.sv */
// types for the wide timer capture and pwm block
package tcp_pkg;
  // pwm resolution select
  typedef enum logic [1:0] {
    TCP_RES_OFF,
    TCP_RES_8,
    TCP_RES_9,
    TCP_RES_10
  } tcp_res_t;
  // counting direction in pwm mode
  typedef enum logic {
    TCP_DIR_UP,
    TCP_DIR_DOWN
  } tcp_dir_t;
endpackage : tcp_pkg

/* hdl/tcp_pwm_channel.sv */
// one pwm compare channel: holding value, latch at top, output
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tcp_pwm_channel
  import tcp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // counter state
  input  wire logic        pwm_on,
  input  wire logic        tick,
  input  wire logic [15:0] count,
  input  wire logic        dir_down,
  input  wire logic        at_top,
  // cpu write of full compare word
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  out_mode,
  // results
  output logic [15:0]      rd_value,
  output logic             match,
  output logic             pin_out
);
  logic [15:0] active_r;   // value in use by the comparator
  logic [15:0] hold_r;     // most recent value written in pwm mode
  logic        pend_r;     // holding value waits for top
  logic        hit;
  logic        out_nxt;
  logic        eff_down;   // direction as seen by the output action

  // a hit at top acts as a down match and a hit at zero as an up
  // match, so a compare of zero or top gives a steady level
  assign eff_down = at_top || (dir_down && count != `TCP_ZERO16); // RL11

  // compare only ten low bits in pwm mode
  assign hit = pwm_on ? (count[9:0] == active_r[9:0]) :
                        (count == active_r); // RL7
  // reads show the newest written word
  assign rd_value = pend_r ? hold_r : active_r; // RL10
  // mode 10 clears going up, mode 11 sets going up
  always_comb begin
    out_nxt = pin_out;
    if (pwm_on && tick && hit) begin
      if (out_mode == `TCP_OM_CLR_UP) out_nxt = eff_down; // RL8
      else if (out_mode == `TCP_OM_SET_UP) out_nxt = !eff_down; // RL8
    end
  end

  // holding register moves at top, zero/top handled by match
  always_ff @(posedge clk) begin
    if (rst) begin
      active_r <= `TCP_ZERO16;
      hold_r   <= `TCP_ZERO16;
      pend_r   <= 1'b0;
      match    <= 1'b0;
      pin_out  <= 1'b0;
    end else begin
      if (wr_en && !pwm_on) begin
        active_r <= wr_data;
        pend_r   <= 1'b0;
      end else if (wr_en) begin
        hold_r <= wr_data; // RL9
        pend_r <= 1'b1;
      end else if (pend_r && at_top) begin
        active_r <= hold_r; // RL9
        pend_r   <= 1'b0;
      end
      match   <= tick && hit; // RL11
      pin_out <= out_nxt; // RL11
    end
  end
endmodule : tcp_pwm_channel

/* hdl/tcp_timer.sv */
// wide timer: input capture, phase-correct pwm, byte register access
// How it works
// RL1: capture edge snapshots counter, sets flag
// RL2: low read latches high byte into temp
// RL3: software reads low byte before high
// RL4: one temp byte shared; software masks interrupts
// RL5: pwm counts zero up to top, back
// RL6: eight, nine, ten bit top values
// RL7: compare counter with ten low bits
// RL8: mode field picks normal or inverted output
// RL9: pwm compare writes wait until top
// RL10: reads return newest written compare value
// RL11: zero or top drive fixed level
// RL12: overflow flag set leaving zero
// RL13: flag and mask and global request interrupt
// RL14: edge select picks rising or falling
// RL15: noise canceller needs four equal samples
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tcp_timer
  import tcp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // i/o register bus from cpu core
  input  wire logic [5:0] io_addr,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [7:0] io_wdata,
  output logic [7:0]      io_rdata,
  // control bits held outside this block
  input  wire logic       tick,
  input  wire tcp_res_t   pwm_res,
  input  wire logic [1:0] output_mode_a,
  input  wire logic [1:0] output_mode_b,
  input  wire logic       capture_edge_select,
  input  wire logic       capture_noise_cancel,
  // interrupt masks and flag clears
  input  wire logic       global_int_en,
  input  wire logic       mask_capture,
  input  wire logic       mask_overflow,
  input  wire logic       mask_cmp_a,
  input  wire logic       mask_cmp_b,
  input  wire logic       clr_capture,
  input  wire logic       clr_overflow,
  input  wire logic       clr_cmp_a,
  input  wire logic       clr_cmp_b,
  // pins
  input  wire logic       capture_input_pin,
  output logic            compare_output_a,
  output logic            compare_output_b,
  // flags and requests
  output logic            capture_event_flag,
  output logic            wide_overflow_flag,
  output logic            compare_flag_a,
  output logic            compare_flag_b,
  output logic            irq_capture,
  output logic            irq_overflow,
  output logic            irq_cmp_a,
  output logic            irq_cmp_b
);
  logic [15:0] wide_counter_r;    // the counter itself
  logic [15:0] wide_counter_nxt;
  logic [15:0] capture_snapshot_r; // read-only capture value
  logic [7:0]  temp_r;            // shared temporary byte
  tcp_dir_t    dir_r;             // pwm counting direction
  tcp_dir_t    dir_nxt;
  logic        pwm_on;
  logic [15:0] top;
  logic        at_top;
  logic        at_zero;
  logic        cap_trig;
  logic        leave_zero;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic        match_a;
  logic        match_b;
  logic        pin_a;
  logic        pin_b;
  logic        wr_cnt;
  logic        wr_a;
  logic        wr_b;
  logic [15:0] wr_word;
  logic        rd_low;
  logic [7:0]  rd_mux;
  logic [15:0] low_src;           // word behind the low byte being read

  // register map, byte wide, low byte on the even address:
  //   counter   2c low, 2d high
  //   compare a 2a low, 2b high
  //   compare b 28 low, 29 high
  //   capture   26 low, 27 high, read only
  // every high byte goes through temp_r in both directions, so
  // a 16-bit access is two bus cycles that must come in order:
  // writes high then low, reads low then high.
  // an interrupt handler that touches any of these words between
  // the two halves of a main-code access corrupts temp_r; the
  // block cannot detect this, software must mask interrupts.
  // high byte writes to an odd address load temp_r even for the
  // read-only capture word; its low byte write is simply dropped.

  // selects the high or low byte of a sixteen-bit word by the hi argument
  function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                           input logic        hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte

  // top from resolution
  assign pwm_on = pwm_res != TCP_RES_OFF;
  assign top    = (pwm_res == TCP_RES_8) ? `TCP_TOP_8 :
                  (pwm_res == TCP_RES_9) ? `TCP_TOP_9 :
                  `TCP_TOP_10; // RL6
  assign at_top  = pwm_on && wide_counter_r == top;
  assign at_zero = wide_counter_r == `TCP_ZERO16;

  // pwm turns at top and at zero; otherwise plain up count
  assign dir_nxt = !pwm_on ? TCP_DIR_UP :
                   at_top  ? TCP_DIR_DOWN :
                   at_zero ? TCP_DIR_UP : dir_r; // RL5
  assign wide_counter_nxt = (pwm_on && dir_nxt == TCP_DIR_DOWN) ?
                            wide_counter_r - `TCP_ONE16 :
                            wide_counter_r + `TCP_ONE16; // RL5
  // advancing away from zero marks overflow in pwm mode
  // in normal mode the flag marks the wrap from all ones instead
  assign leave_zero = pwm_on ? (tick && at_zero) :
                      (tick && wide_counter_r == `TCP_ALL_ONES16); // RL12

  // byte writes: high byte goes to temp, low byte commits all 16
  assign wr_word = {temp_r, io_wdata}; // RL4
  assign wr_cnt  = io_wr && io_addr == `TCP_ADDR_CNT_L;
  assign wr_a    = io_wr && io_addr == `TCP_ADDR_CMPA_L;
  assign wr_b    = io_wr && io_addr == `TCP_ADDR_CMPB_L;
  // low byte reads latch the high byte into temp
  assign rd_low  = io_rd && (io_addr == `TCP_ADDR_CAP_L ||
                   io_addr == `TCP_ADDR_CNT_L ||
                   io_addr == `TCP_ADDR_CMPA_L ||
                   io_addr == `TCP_ADDR_CMPB_L); // RL2
  // high half that a low byte read parks in temp_r
  assign low_src = (io_addr == `TCP_ADDR_CAP_L)  ? capture_snapshot_r :
                   (io_addr == `TCP_ADDR_CNT_L)  ? wide_counter_r :
                   (io_addr == `TCP_ADDR_CMPA_L) ? rd_a : rd_b;

  // read data select; high bytes return temp, not live data
  always_comb begin
    case (io_addr)
      `TCP_ADDR_CAP_L:  rd_mux = pick_byte(capture_snapshot_r, 1'b0);
      `TCP_ADDR_CNT_L:  rd_mux = pick_byte(wide_counter_r, 1'b0);
      `TCP_ADDR_CMPA_L: rd_mux = pick_byte(rd_a, 1'b0);
      `TCP_ADDR_CMPB_L: rd_mux = pick_byte(rd_b, 1'b0);
      `TCP_ADDR_CAP_H,
      `TCP_ADDR_CNT_H,
      `TCP_ADDR_CMPA_H,
      `TCP_ADDR_CMPB_H: rd_mux = temp_r; // RL2
      default:          rd_mux = 8'h00;
    endcase
  end

  // capture pin path
  // the filter sits behind its own two-flop synchroniser, so the
  // trigger lags the pin by at least three clocks; the counter
  // value snapshot is the one standing when the trigger arrives.
  // the lag is fixed, so software can subtract it if it matters.
  tcp_capture_filter u_cap (
    .clk                  (clk),
    .rst                  (rst),
    .capture_input_pin    (capture_input_pin),
    .capture_edge_select  (capture_edge_select),
    .capture_noise_cancel (capture_noise_cancel),
    .capture_trig         (cap_trig)
  );

  // both channels share the counter, direction and top detect;
  // only the write strobe and the output mode differ.
  // the compare words are read back through the channels so that
  // a pending pwm write shows the newest value.
  // channel a
  tcp_pwm_channel u_ch_a (
    .clk      (clk),
    .rst      (rst),
    .pwm_on   (pwm_on),
    .tick     (tick),
    .count    (wide_counter_r),
    .dir_down (dir_r == TCP_DIR_DOWN),
    .at_top   (at_top),
    .wr_en    (wr_a),
    .wr_data  (wr_word),
    .out_mode (output_mode_a),
    .rd_value (rd_a),
    .match    (match_a),
    .pin_out  (pin_a)
  );

  // channel b
  tcp_pwm_channel u_ch_b (
    .clk      (clk),
    .rst      (rst),
    .pwm_on   (pwm_on),
    .tick     (tick),
    .count    (wide_counter_r),
    .dir_down (dir_r == TCP_DIR_DOWN),
    .at_top   (at_top),
    .wr_en    (wr_b),
    .wr_data  (wr_word),
    .out_mode (output_mode_b),
    .rd_value (rd_b),
    .match    (match_b),
    .pin_out  (pin_b)
  );

  // counter, direction, temp byte and capture register
  // a cpu preset beats the tick in the same cycle, and the
  // direction is left alone then; after a preset above top while
  // counting up the counter runs up and wraps, which software must avoid.
  // temp_r has one writer: a high write beats a low read, they
  // cannot come together on a single-master bus anyway.
  // the snapshot takes the counter before this edge's update,
  // matching the value the trigger was raised against.
  always_ff @(posedge clk) begin
    if (rst) begin
      wide_counter_r     <= `TCP_ZERO16;
      dir_r              <= TCP_DIR_UP;
      temp_r             <= 8'h00;
      capture_snapshot_r <= `TCP_ZERO16;
    end else begin
      if (wr_cnt) wide_counter_r <= wr_word; // cpu preset wins
      else if (tick) begin
        wide_counter_r <= wide_counter_nxt;
        dir_r          <= dir_nxt;
      end
      // one temp shared by all four registers
      if (io_wr && io_addr[0]) temp_r <= io_wdata; // RL4
      else if (rd_low) temp_r <= pick_byte(low_src, 1'b1); // RL2
      if (cap_trig) capture_snapshot_r <= wide_counter_r; // RL1
    end
  end

  // sticky flags: a set in the clear cycle wins
  // losing an event is worse than a spurious second service, so
  // an event that lands on the clear strobe keeps the flag up.
  // the clear strobes are single-cycle pulses from outside.
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_event_flag <= 1'b0;
      wide_overflow_flag <= 1'b0;
      compare_flag_a     <= 1'b0;
      compare_flag_b     <= 1'b0;
    end else begin
      capture_event_flag <= cap_trig | (capture_event_flag & ~clr_capture); // RL1
      wide_overflow_flag <= leave_zero |
                            (wide_overflow_flag & ~clr_overflow); // RL12
      compare_flag_a <= match_a | (compare_flag_a & ~clr_cmp_a); // RL13
      compare_flag_b <= match_b | (compare_flag_b & ~clr_cmp_b); // RL13
    end
  end

  // registered outputs: requests, pins, read data
  // every output leaves from a flop; this costs one cycle of lag
  // on the requests and pins but keeps glitches off the ports.
  // read data is zero outside a read so the bus can be or-ed.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_capture      <= 1'b0;
      irq_overflow     <= 1'b0;
      irq_cmp_a        <= 1'b0;
      irq_cmp_b        <= 1'b0;
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      io_rdata         <= 8'h00;
    end else begin
      irq_capture  <= capture_event_flag & mask_capture & global_int_en; // RL13
      irq_overflow <= wide_overflow_flag & mask_overflow & global_int_en; // RL13
      irq_cmp_a    <= compare_flag_a & mask_cmp_a & global_int_en; // RL13
      irq_cmp_b    <= compare_flag_b & mask_cmp_b & global_int_en; // RL13
      compare_output_a <= pin_a;
      compare_output_b <= pin_b;
      io_rdata <= io_rd ? rd_mux : 8'h00;
    end
  end
endmodule : tcp_timer

/* sim/tb_top.sv */
// self-checking bench for the wide timer capture and pwm block
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tb_top
  import tcp_pkg::*;
;
  logic clk, rst, io_rd, io_wr, tick, capture_edge_select;
  logic capture_noise_cancel, global_int_en, mask_capture, mask_overflow;
  logic mask_cmp_a, mask_cmp_b, clr_capture, clr_overflow, clr_cmp_a;
  logic clr_cmp_b, capture_input_pin, compare_output_a, compare_output_b;
  logic capture_event_flag, wide_overflow_flag, compare_flag_a;
  logic compare_flag_b;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, b;
  logic [1:0]  output_mode_a, output_mode_b;
  logic [15:0] w, v;
  tcp_res_t    pwm_res;
  int          fails, n_compared, n;
  tcp_timer i_tcp_timer (.clk(clk), .rst(rst), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .tick(tick), .pwm_res(pwm_res), .output_mode_a(output_mode_a),
    .output_mode_b(output_mode_b), .capture_edge_select(capture_edge_select),
    .capture_noise_cancel(capture_noise_cancel), .mask_cmp_a(mask_cmp_a),
    .global_int_en(global_int_en), .mask_capture(mask_capture),
    .mask_overflow(mask_overflow), .mask_cmp_b(mask_cmp_b),
    .clr_capture(clr_capture), .clr_overflow(clr_overflow),
    .clr_cmp_a(clr_cmp_a), .clr_cmp_b(clr_cmp_b),
    .capture_input_pin(capture_input_pin), .irq_cmp_b(),
    .compare_output_a(compare_output_a), .irq_capture(),
    .compare_output_b(compare_output_b), .irq_overflow(), .irq_cmp_a(),
    .capture_event_flag(capture_event_flag), .compare_flag_a(compare_flag_a),
    .wide_overflow_flag(wide_overflow_flag), .compare_flag_b(compare_flag_b));
  tcp_cpu_model i_tcp_cpu_model (.clk(clk), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata));
  // free running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts, verdict and stop, shared by the timeout path
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // k edges, inputs then move 1 ns later
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  function automatic logic pick(input int s);
    case (s)
      0: pick = capture_event_flag;
      1: pick = wide_overflow_flag;
      2: pick = compare_output_a;
      default: pick = compare_output_b;
    endcase
  endfunction : pick
  // bounded wait for a level; a hang ends the run as a mismatch
  task automatic wait_for(input int s, input logic lvl, output int k);
    k = 0;
    while (pick(s) !== lvl) begin
      cyc(1);
      k++;
      if (k > 3000) begin
        fails++;
        complete_run();
      end
    end
  endtask : wait_for
  initial begin
    {rst, tick, output_mode_a, output_mode_b, capture_input_pin} = 7'h40;
    {capture_edge_select, capture_noise_cancel, global_int_en} = 3'h7;
    {mask_capture, mask_overflow, mask_cmp_a, mask_cmp_b} = 4'he;
    {clr_capture, clr_overflow, clr_cmp_a, clr_cmp_b} = 4'h0;
    pwm_res = TCP_RES_OFF;
    fails = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    // reset values and an unmapped byte
    for (int i = 0; i < 4; i++) begin
      i_tcp_cpu_model.rd16(6'h2c - 6'(2 * i), w);
      check(w, 16'h0000);
    end
    i_tcp_cpu_model.rd8(6'h30, b);
    check({8'h00, b}, 16'h0000);
    $display("reset test done");
    // frozen counter, rising edge with canceller on
    i_tcp_cpu_model.wr16(`TCP_ADDR_CNT_L, 16'ha5c3);
    cyc(10);
    capture_input_pin = 1'b1;
    wait_for(0, 1'b1, n);
    cyc(10);
    i_tcp_cpu_model.rd16(`TCP_ADDR_CAP_L, w);
    check(w, 16'ha5c3);
    i_tcp_cpu_model.rd8(`TCP_ADDR_CAP_L, b);
    i_tcp_cpu_model.rd8(`TCP_ADDR_CNT_H, b);
    check({8'h00, b}, 16'h00a5);
    // two-sample glitch must be filtered out
    clr_capture = 1'b1;
    capture_input_pin = 1'b0;
    cyc(1);
    clr_capture = 1'b0;
    cyc(10);
    capture_input_pin = 1'b1;
    cyc(2);
    capture_input_pin = 1'b0;
    cyc(12);
    check({15'h0, capture_event_flag}, 16'h0000);
    // falling edge selected, canceller off: rise ignored, fall captures
    {capture_edge_select, capture_noise_cancel, global_int_en} = 3'h0;
    cyc(2);
    clr_capture = 1'b1;
    cyc(1);
    clr_capture = 1'b0;
    capture_input_pin = 1'b1;
    cyc(12);
    check({15'h0, capture_event_flag}, 16'h0000);
    capture_input_pin = 1'b0;
    wait_for(0, 1'b1, n);
    check(16'(n), 16'd4);
    $display("capture test done");
    // period of twice top at every resolution
    {tick, global_int_en} = 2'h3;
    for (int r = 1; r < 4; r++) begin
      pwm_res = tcp_res_t'(r);
      v = r == 1 ? `TCP_TOP_8 : r == 2 ? `TCP_TOP_9 : `TCP_TOP_10;
      i_tcp_cpu_model.wr16(`TCP_ADDR_CNT_L, 16'h0000);
      cyc(1);
      wait_for(1, 1'b1, n);
      clr_overflow = 1'b1;
      cyc(1);
      clr_overflow = 1'b0;
      wait_for(1, 1'b1, n);
      check(16'(n + 1), {v[14:0], 1'b0});
    end
    $display("period test done");
    // pulse widths from ten-bit compares, normal and inverted
    pwm_res = TCP_RES_8;
    output_mode_a = `TCP_OM_CLR_UP;
    output_mode_b = `TCP_OM_SET_UP;
    i_tcp_cpu_model.wr16(`TCP_ADDR_CMPA_L, 16'hfc64);
    i_tcp_cpu_model.wr16(`TCP_ADDR_CMPB_L, 16'h0064);
    cyc(600);
    wait_for(2, 1'b0, n);
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    check(16'(n), 16'd200);
    wait_for(3, 1'b1, n);
    wait_for(3, 1'b0, n);
    wait_for(3, 1'b1, n);
    check(16'(n), 16'd200);
    check({14'h0, compare_flag_a, compare_flag_b}, 16'h0003);
    i_tcp_cpu_model.wr16(`TCP_ADDR_CMPA_L, 16'h0037);
    i_tcp_cpu_model.rd16(`TCP_ADDR_CMPA_L, w);
    check(w, 16'h0037);
    // zero and top give steady levels over a whole period
    for (int j = 0; j < 2; j++) begin
      v = j == 0 ? `TCP_ZERO16 : `TCP_TOP_8;
      i_tcp_cpu_model.wr16(`TCP_ADDR_CMPA_L, v);
      i_tcp_cpu_model.wr16(`TCP_ADDR_CMPB_L, v);
      cyc(1100);
      for (int k = 0; k < 8; k++) begin
        cyc(65);
        check({14'h0, compare_output_a, compare_output_b}, 16'(j + 1));
      end
    end
    $display("output test done");
    complete_run();
  end
endmodule : tb_top

/* sim/tcp_cpu_model.sv */
// cpu core model driving the byte-wide i/o register bus
`timescale 1ns/100ps
module tcp_cpu_model (
  // clock
  input  wire logic       clk,
  // i/o register bus towards the timer
  output logic      [5:0] io_addr,
  output logic            io_rd,
  output logic            io_wr,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  // idle bus from time zero
  initial begin
    io_addr  = 6'h3f;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 8'h5a;
  end
  // byte write; data line then shows the inverse, never a stale copy
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(posedge clk);
    #1;
    io_wr    = 1'b0;
    io_wdata = ~d;
  endtask : wr8
  // byte read; answer is registered, taken one edge after the strobe
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge clk);
    #1;
    d       = io_rdata;
    io_rd   = 1'b0;
  endtask : rd8
  // high byte first so the low write lands both halves at once
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a + 6'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16
  // low byte first, high comes back from the shared temp byte
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 6'h01, d[15:8]);
  endtask : rd16
endmodule : tcp_cpu_model

/* sim/tcp_timer_checker.sv */
// assertion checker for the wide timer block
`timescale 1ns/100ps
module tcp_timer_checker
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // bus read side
  input wire logic       io_rd,
  input wire logic [7:0] io_rdata,
  // pins and controls
  input wire logic [1:0] output_mode_a,
  input wire logic       compare_output_a,
  input wire logic       capture_input_pin,
  input wire logic       capture_edge_select,
  input wire logic       clr_capture,
  input wire logic       clr_overflow,
  input wire logic       global_int_en,
  input wire logic       mask_capture,
  input wire logic       mask_overflow,
  input wire logic       mask_cmp_a,
  // flags and requests
  input wire logic       capture_event_flag,
  input wire logic       wide_overflow_flag,
  input wire logic       compare_flag_a,
  input wire logic       irq_capture,
  input wire logic       irq_overflow,
  input wire logic       irq_cmp_a
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // pin settled low, then high, rising edge chosen, no clear
  sequence low_run;
    (!capture_input_pin && capture_edge_select && !clr_capture)[*8];
  endsequence
  sequence high_run;
    (capture_input_pin && capture_edge_select && !clr_capture)[*8];
  endsequence
  // eight high samples outlast sync, canceller and trigger stages
  cap_on_edge_a: assert property (low_run ##1 high_run |-> ##2 capture_event_flag)
    else $error("capture flag missing after rising edge");
  cap_flag_sticky_a: assert property (capture_event_flag && !clr_capture |=> capture_event_flag)
    else $error("capture flag dropped without clear");
  ovf_flag_hold_a: assert property ($fell(wide_overflow_flag) |-> $past(clr_overflow))
    else $error("overflow flag dropped without clear");
  irq_capture_a: assert property (irq_capture == $past(capture_event_flag && mask_capture && global_int_en))
    else $error("capture request not flag and masks");
  irq_ovf_rise_a: assert property ($rose(irq_overflow) |-> $past(wide_overflow_flag && mask_overflow && global_int_en))
    else $error("overflow request without cause");
  irq_cmp_req_a: assert property (compare_flag_a && mask_cmp_a && global_int_en |=> irq_cmp_a)
    else $error("compare request missing");
  rdata_idle_a: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data without a read");
  mode_off_a: assert property ((!output_mode_a[1])[*3] |-> $stable(compare_output_a))
    else $error("output moved while disconnected");
endmodule : tcp_timer_checker

bind tcp_timer tcp_timer_checker i_tcp_timer_checker (
  .clk(clk), .rst(rst), .io_rd(io_rd), .io_rdata(io_rdata),
  .output_mode_a(output_mode_a), .compare_output_a(compare_output_a),
  .capture_input_pin(capture_input_pin), .clr_capture(clr_capture),
  .capture_edge_select(capture_edge_select), .clr_overflow(clr_overflow),
  .global_int_en(global_int_en), .mask_capture(mask_capture),
  .mask_overflow(mask_overflow), .mask_cmp_a(mask_cmp_a),
  .capture_event_flag(capture_event_flag), .irq_capture(irq_capture),
  .wide_overflow_flag(wide_overflow_flag), .irq_overflow(irq_overflow),
  .compare_flag_a(compare_flag_a), .irq_cmp_a(irq_cmp_a));
